/* File: pkg/zq_train_pkg.sv */
// constants, types and encodings shared by the calibration and training block
`default_nettype none
package zq_train_pkg;
   localparam int CA_W = 10;
   localparam int DQ_W = 16;
   localparam int LEN_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // software register offsets (byte addresses, one word each)
   localparam logic [7:0] REG_LEN_BASE = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_ECHO = 8'h14;

   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_OP = 1;
   localparam int ST_TRAIN = 3;
   localparam int ST_REMAP = 4;
   localparam int ST_DEFAULT = 5;
   localparam int ST_ECHO = 6;
   localparam int ST_CKE_ERR = 7;
   localparam int ST_CMD_ERR = 8;

   // reset values of the calibration lengths, in clock cycles
   localparam logic [15:0] LEN_INIT_RST = 16'h0400;
   localparam logic [15:0] LEN_RESET_RST = 16'h0010;
   localparam logic [15:0] LEN_LONG_RST = 16'h0100;
   localparam logic [15:0] LEN_SHORT_RST = 16'h0040;

   // mode-register addresses and operands
   localparam logic [7:0] MR_CAL_ADDR = 8'h0A;
   localparam logic [7:0] MR_TRAIN_ENTRY = 8'h29;
   localparam logic [7:0] OP_TRAIN_ENTRY = 8'hA4;
   localparam logic [7:0] MR_TRAIN_EXIT = 8'h2A;
   localparam logic [7:0] OP_TRAIN_EXIT = 8'hA8;
   localparam logic [7:0] MR_TRAIN_REMAP = 8'h30;
   localparam logic [7:0] OP_TRAIN_REMAP = 8'hC0;
   localparam logic [7:0] OP_CAL_INIT = 8'h01;
   localparam logic [7:0] OP_CAL_RESET = 8'h02;
   localparam logic [7:0] OP_CAL_LONG = 8'h03;
   localparam logic [7:0] OP_CAL_SHORT = 8'h04;

   typedef enum logic [1:0] {
      CAL_INIT = 2'b00,
      CAL_RESET = 2'b01,
      CAL_LONG = 2'b10,
      CAL_SHORT = 2'b11
   } cal_op_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_CAL = 2'b01,
      S_TRAIN = 2'b10
   } dev_state_e;

   typedef struct packed {
      logic cs_n;
      logic cke;
      logic [CA_W-1:0] rise;
      logic [CA_W-1:0] fall;
   } ca_pins_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage : zq_train_pkg
`default_nettype wire

/* File: hw/zq_cal_and_ca_training.sv */
// impedance calibration sequencer and command/address training echo
//
// How it works
// - calibration starts only from a mode-register write
// - impedance reset restores default, busy for its programmed length
// - write 29H operand A4H enters training
// - write 2AH operand A8H exits training
// - entry/exit decode takes address and operand from both edges
// - first phase echoes eight CA pins on DQ
// - remap write switches echo to CA4, CA9
// - unused DQ driven valid, strobe static
// - echo launched once all samples are in
// - repeated commands allowed, delays from last select
// - write 30H operand C0H selects remap phase
// - CA4 to DQ0/DQ1, CA9 to DQ8/DQ9
// - write decoded from CA0-CA3 low, fields split
`default_nettype none
module zq_cal_and_ca_training
   import zq_train_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // command/address pins, one sample per edge
   input wire logic cs_n,
   input wire logic cke,
   input wire logic [CA_W-1:0] ca_rise,
   input wire logic [CA_W-1:0] ca_fall,
   // data pins
   output logic [DQ_W-1:0] dq_out,
   output logic [DQ_W-1:0] dq_oe,
   output logic dqs_out,
   output logic dqs_oe,
   // state seen from outside
   output logic cal_busy,
   output logic train_mode,
   output logic impedance_default,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata
);

   // pin synchroniser: first stage is read only by the second
   ca_pins_s pin_now;
   ca_pins_s pin_meta;
   ca_pins_s pin;

   assign pin_now = '{cs_n: cs_n, cke: cke, rise: ca_rise, fall: ca_fall};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= '{cs_n: 1'b1, cke: 1'b0, rise: '0, fall: '0};
         pin <= '{cs_n: 1'b1, cke: 1'b0, rise: '0, fall: '0};
      end else begin
         pin_meta <= pin_now;
         pin <= pin_meta;
      end
   end

   reg_req_s req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // command decode
   wire selected = !pin.cs_n;
   wire mrw_hit = selected && (pin.rise[3:0] == 4'h0);
   wire [7:0] mr_addr = {pin.fall[1:0], pin.rise[9:4]};
   wire [7:0] mr_op = pin.fall[9:2];

   // entry and exit words are split across the edges: address from rise CA4-9
   // and fall CA0-1, operand from fall CA2-9, so both edge samples must be right
   wire entry_hit = mrw_hit && mr_addr == MR_TRAIN_ENTRY && mr_op == OP_TRAIN_ENTRY;
   wire exit_hit = mrw_hit && mr_addr == MR_TRAIN_EXIT && mr_op == OP_TRAIN_EXIT;
   wire remap_hit = mrw_hit && mr_addr == MR_TRAIN_REMAP && mr_op == OP_TRAIN_REMAP;
   wire cal_hit = mrw_hit && (mr_addr == MR_CAL_ADDR);

   cal_op_e hit_op;
   wire hit_known;

   assign hit_op = (mr_op == OP_CAL_INIT) ? CAL_INIT :
                   (mr_op == OP_CAL_RESET) ? CAL_RESET :
                   (mr_op == OP_CAL_LONG) ? CAL_LONG : CAL_SHORT;
   assign hit_known = mr_op == OP_CAL_INIT || mr_op == OP_CAL_RESET ||
                      mr_op == OP_CAL_LONG || mr_op == OP_CAL_SHORT;

   // programmable lengths, one per operation
   logic [LEN_W-1:0] cal_len [4];
   localparam logic [15:0] LEN_RST [4] = '{LEN_INIT_RST, LEN_RESET_RST,
                                           LEN_LONG_RST, LEN_SHORT_RST};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_len
         localparam logic [7:0] LEN_OFS = REG_LEN_BASE + 8'(gi * 4);
         wire len_wr = req.wr && (req.addr == LEN_OFS);

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               cal_len[gi] <= LEN_RST[gi];
            end else if (len_wr) begin
               cal_len[gi] <= req.wdata[LEN_W-1:0];
            end
         end
      end
   endgenerate

   // control state
   dev_state_e state;
   dev_state_e next_state;
   logic [LEN_W-1:0] cal_cnt;
   logic [LEN_W-1:0] next_cal_cnt;
   cal_op_e cur_op;
   logic remap;
   logic next_remap;
   logic echo_on;
   logic next_echo_on;
   logic [DQ_W-1:0] echo_word;
   logic cke_err;
   logic cmd_err;

   wire in_idle = state == S_IDLE;
   wire in_cal = state == S_CAL;
   wire in_train = state == S_TRAIN;
   wire cal_start = in_idle && cal_hit && hit_known;
   wire [LEN_W-1:0] hit_len = cal_len[hit_op];
   // a zero length would never finish, so it counts as one cycle
   wire [LEN_W-1:0] load_len = (hit_len == '0) ? LEN_W'(1) : hit_len;
   wire cal_last = in_cal && (cal_cnt == LEN_W'(1));

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: begin
            if (entry_hit) begin
               next_state = S_TRAIN;
            end else if (cal_start) begin
               next_state = S_CAL;
            end
         end
         S_CAL: begin
            // commands during the period are not acted upon
            if (cal_last) begin
               next_state = S_IDLE;
            end
         end
         S_TRAIN: begin
            if (exit_hit) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   assign next_cal_cnt = cal_start ? load_len :
                         (in_cal && cal_cnt != '0) ? cal_cnt - LEN_W'(1) : cal_cnt;

   // remap holds until exit; a fresh entry restarts at phase one
   assign next_remap = in_train && !exit_hit && (remap || remap_hit);

   // any select in training except the exit write, repeated writes included, relaunches the echo
   assign next_echo_on = in_train && !exit_hit && (echo_on || selected);

   // echo map, first phase: CA0-3, CA5-8 onto even/odd DQ pairs
   logic [DQ_W-1:0] map_first;
   logic [DQ_W-1:0] map_remap;

   generate
      for (gi = 0; gi < 8; gi++) begin : g_map
         localparam int CA_IDX = (gi < 4) ? gi : gi + 1;
         assign map_first[2*gi] = pin.rise[CA_IDX];
         assign map_first[2*gi+1] = pin.fall[CA_IDX];
      end
   endgenerate

   // remapped phase: unused pins sit at a valid low
   assign map_remap = {6'h00, pin.fall[9], pin.rise[9], 6'h00, pin.fall[4], pin.rise[4]};

   wire [DQ_W-1:0] map_now = (remap || remap_hit) ? map_remap : map_first;
   wire echo_take = in_train && selected && !exit_hit;

   // impedance default flag: set by the reset op, cleared by a real calibration
   logic next_default;

   assign next_default = (cal_start && hit_op == CAL_RESET) ? 1'b1 :
                         (cal_start && hit_op != CAL_RESET) ? 1'b0 :
                         impedance_default;

   // protocol watch during calibration; a new event beats a clear
   wire st_wr = req.wr && (req.addr == REG_STATUS);
   wire cke_evt = in_cal && !pin.cke;
   wire cmd_evt = in_cal && selected;
   wire next_cke_err = cke_evt || (cke_err && !(st_wr && req.wdata[ST_CKE_ERR]));
   wire next_cmd_err = cmd_evt || (cmd_err && !(st_wr && req.wdata[ST_CMD_ERR]));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
         cal_cnt <= '0;
         cur_op <= CAL_INIT;
         remap <= 1'b0;
         echo_on <= 1'b0;
         echo_word <= '0;
         cke_err <= 1'b0;
         cmd_err <= 1'b0;
      end else begin
         state <= next_state;
         cal_cnt <= next_cal_cnt;
         cur_op <= cal_start ? hit_op : cur_op;
         remap <= next_remap;
         echo_on <= next_echo_on;
         echo_word <= echo_take ? map_now : echo_word;
         cke_err <= next_cke_err;
         cmd_err <= next_cmd_err;
      end
   end

   // pins: DQ released during calibration and outside training,
   // strobe held static and undriven in every state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dq_out <= '0;
         dq_oe <= '0;
         dqs_out <= 1'b0;
         dqs_oe <= 1'b0;
      end else begin
         dq_out <= echo_take ? map_now : (next_echo_on ? dq_out : '0);
         dq_oe <= {DQ_W{next_echo_on}};
         dqs_out <= 1'b0;
         dqs_oe <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cal_busy <= 1'b0;
         train_mode <= 1'b0;
         impedance_default <= 1'b0;
      end else begin
         cal_busy <= next_state == S_CAL;
         train_mode <= next_state == S_TRAIN;
         impedance_default <= next_default;
      end
   end

   // register read: data stand one cycle after the strobe only
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] len_word;
   logic [DATA_W-1:0] rd_word;

   assign status_word = {23'h000000, cmd_err, cke_err, echo_on, impedance_default,
                         remap, in_train, cur_op, in_cal};
   assign len_word = {16'h0000, cal_len[req.addr[3:2]]};
   wire len_sel = (req.addr[7:4] == REG_LEN_BASE[7:4]) && (req.addr[1:0] == 2'b00);
   assign rd_word = len_sel ? len_word :
                    (req.addr == REG_STATUS) ? status_word :
                    (req.addr == REG_ECHO) ? {16'h0000, echo_word} : '0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= req.rd ? rd_word : '0;
      end
   end
endmodule : zq_cal_and_ca_training
`default_nettype wire

/* File: testbench/ca_ctrl_model.sv */
// memory controller model driving the command/address pins
`default_nettype none
module ca_ctrl_model
   import zq_train_pkg::*;
(
   // clock
   input wire logic clk,
   // command/address pins
   output logic cs_n,
   output logic cke,
   output logic [CA_W-1:0] ca_rise,
   output logic [CA_W-1:0] ca_fall
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n = 1'h1;
      // clock never shifted here, so the deselected-shift allowance is unused
      cke = 1'h1;
      ca_rise = 10'h0;
      ca_fall = 10'h0;
   end
   // lines flip on deselect so a stale value never reads as held
   task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
      @(posedge clk);
      cs_n <= 1'h0;
      ca_rise <= r;
      ca_fall <= f;
      @(posedge clk);
      cs_n <= 1'h1;
      ca_rise <= ~r;
      ca_fall <= ~f;
   endtask : cmd
   task automatic mrw(input logic [7:0] a, input logic [7:0] op);
      cmd({a[5:0], 4'h0}, {op, a[7:6]});
   endtask : mrw
endmodule : ca_ctrl_model
`default_nettype wire

/* File: testbench/zq_train_chk.sv */
// port assertions for the calibration and training block
`default_nettype none
module zq_train_chk
   import zq_train_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // command pins
   input wire logic cs_n,
   input wire logic [CA_W-1:0] ca_rise,
   input wire logic [CA_W-1:0] ca_fall,
   // outputs
   input wire logic [DQ_W-1:0] dq_oe,
   input wire logic dqs_oe,
   input wire logic cal_busy,
   input wire logic train_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // pin commands act two cycles later, behind the synchronisers
   wire logic mrw = !cs_n && ca_rise[3:0] == 4'h0;
   wire logic [7:0] ma = {ca_fall[1:0], ca_rise[9:4]};
   wire logic [7:0] mo = ca_fall[9:2];
   wire logic ent = mrw && ma == MR_TRAIN_ENTRY && mo == OP_TRAIN_ENTRY;
   wire logic ext = mrw && ma == MR_TRAIN_EXIT && mo == OP_TRAIN_EXIT;
   wire logic cal = mrw && ma == MR_CAL_ADDR && mo != 8'h00 && mo <= OP_CAL_SHORT;
   a_strobe_still: assert property (dqs_oe == 1'h0)
      else $error("strobe driven");
   a_oe_whole: assert property (dq_oe == 16'h0 || dq_oe == 16'hFFFF)
      else $error("split oe");
   a_entry_taken: assert property (ent ##2 !cal_busy |=> train_mode)
      else $error("entry missed");
   a_entry_refused: assert property (ent ##2 cal_busy |=> !train_mode)
      else $error("entry during calibration");
   a_exit_taken: assert property (ext ##2 !cal_busy |=> !train_mode && dq_oe == 16'h0)
      else $error("exit missed");
   a_echo_driven: assert property ((!cs_n && !ext) ##2 train_mode |=> dq_oe == 16'hFFFF)
      else $error("echo not driven");
   a_cal_started: assert property (cal ##2 (!cal_busy && !train_mode) |=> cal_busy)
      else $error("calibration missed");
   a_cal_quiet: assert property (cal_busy |-> dq_oe == 16'h0 && !train_mode)
      else $error("bus driven in calibration");
endmodule : zq_train_chk
bind zq_cal_and_ca_training zq_train_chk i_zq_train_chk (.clk, .rstn, .cs_n, .ca_rise,
   .ca_fall, .dq_oe, .dqs_oe, .cal_busy, .train_mode);
`default_nettype wire

/* File: testbench/test_zq_cal_and_ca_training.sv */
// self-checking bench for the calibration and training block
`default_nettype none
module test_zq_cal_and_ca_training
   import zq_train_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, remap = 1'h0;
   logic cs_n, cke, dqs_out, dqs_oe, cal_busy, train_mode, impedance_default;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, rv;
   logic [CA_W-1:0] ca_rise, ca_fall, r, f;
   logic [DQ_W-1:0] dq_out, dq_oe;
   logic [15:0] rst_len[4] = '{LEN_INIT_RST, LEN_RESET_RST, LEN_LONG_RST, LEN_SHORT_RST};
   int errors = 0, total_checks = 0, cycles = 0, seed = 641, n, lens[4];
   always #25 clk = ~clk;
   zq_cal_and_ca_training i_zq_cal_and_ca_training (.clk, .rstn, .cs_n, .cke, .ca_rise,
      .ca_fall, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .cal_busy, .train_mode,
      .impedance_default, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   ca_ctrl_model i_ca_ctrl_model (.clk, .cs_n, .cke, .ca_rise, .ca_fall);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : settle
   // one register access; read data land in rv
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      #1 rv = reg_rdata;
   endtask : bus
   function automatic logic [15:0] echo(input logic [9:0] a, b, input logic rm);
      int k[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
      echo = 16'h0;
      for (int i = 0; i < 8; i++) begin
         echo[2 * i] = rm ? 1'h0 : a[k[i]];
         echo[2 * i + 1] = rm ? 1'h0 : b[k[i]];
      end
      if (rm) echo[9:8] = {b[9], a[9]};
      if (rm) echo[1:0] = {b[4], a[4]};
   endfunction : echo
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      if (++cycles == 20000) begin
         errors++;
         give_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         bus(1'h0, 8'(4 * i), 32'h0);
         chk(rv, {16'h0, rst_len[i]});
         lens[i] = 4 + ($random(seed) & 7);
         bus(1'h1, 8'(4 * i), 32'(lens[i]));
      end
      bus(1'h0, 8'h20, 32'h0);
      chk(rv, 32'h0);
      // init first, one calibrating device, data bus quiet
      for (int op = 1; op <= 4; op++) begin
         i_ca_ctrl_model.mrw(MR_CAL_ADDR, 8'(op));
         settle(2);
         for (n = 0; cal_busy === 1'h1 && n < 2000; n++) settle(1);
         chk(n, lens[op - 1]);
         chk(impedance_default, op == 2);
      end
      // entry while calibrating must be dropped and flagged
      i_ca_ctrl_model.mrw(MR_CAL_ADDR, OP_CAL_LONG);
      i_ca_ctrl_model.mrw(MR_TRAIN_ENTRY, OP_TRAIN_ENTRY);
      settle(16);
      chk(train_mode, 1'h0);
      bus(1'h0, REG_STATUS, 32'h0);
      chk(rv[ST_CMD_ERR], 1'h1);
      bus(1'h1, REG_STATUS, 32'h100);
      bus(1'h0, REG_STATUS, 32'h0);
      chk(rv[ST_CMD_ERR], 1'h0);
      i_ca_ctrl_model.mrw(MR_TRAIN_ENTRY, OP_TRAIN_ENTRY);
      settle(2);
      chk(train_mode, 1'h1);
      for (int i = 0; i < 12; i++) begin
         r = 10'($random(seed));
         f = 10'($random(seed));
         if (i == 0) {r, f} = {MR_TRAIN_ENTRY[5:0], 4'h0, OP_TRAIN_ENTRY, 2'h0};
         if (i == 6) {r, f} = {MR_TRAIN_REMAP[5:0], 4'h0, OP_TRAIN_REMAP, 2'h0};
         remap = remap || i == 6;
         i_ca_ctrl_model.cmd(r, f);
         settle(2);
         chk(dq_oe, 16'hFFFF);
         chk({dqs_oe, dqs_out}, 2'h0);
         chk(dq_out, echo(r, f, remap));
      end
      // both phases done before leaving training
      i_ca_ctrl_model.mrw(MR_TRAIN_EXIT, OP_TRAIN_EXIT);
      settle(2);
      chk(train_mode, 1'h0);
      chk(dq_oe, 16'h0);
      give_verdict;
   end
endmodule : test_zq_cal_and_ca_training
`default_nettype wire
